// *** sim/tpf_flash_model.sv ***
// Behavioural program flash array as seen from the table read port.
// Assumes the design holds the byte address steady and samples the word at the next clock edge.
`default_nettype none
module tpf_flash_model
  import tpf_pkg::*;
(
  input  wire logic [PTR_W-1:0] addr_in,
  output logic      [15:0]      rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lo_byte;
  // The top bit is folded in so the ID space never reads like program space.
  assign lo_byte = {addr_in[PTR_W-1], addr_in[7:1]};
  // The array reads asynchronously, so the word is settled before the design's sampling edge.
  assign rdata_out = {~lo_byte, lo_byte};
endmodule // tpf_flash_model
`default_nettype wire

// *** sim/tpf_top_tb.sv ***
// Self-checking bench for the table pointer flash block.
// Assumes the block answers each register access one cycle after taking it.
`default_nettype none
module tpf_top_tb;
  import tpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // A short long-cycle count keeps the run brief; expectations follow it.
  localparam int LONGC = 20;
  typedef struct packed {logic [21:0] p; logic [1:0] m; logic [21:0] np;} tpf_row_t;
  localparam tpf_row_t ROWS [7] = '{'{22'h000010, 2'h0, 22'h000010}, '{22'h000011, 2'h1, 22'h000012},
    '{22'h000011, 2'h2, 22'h000010}, '{22'h000011, 2'h3, 22'h000012}, '{22'h1FFFFF, 2'h1, 22'h000000},
    '{22'h200000, 2'h2, 22'h3FFFFF}, '{22'h3FFFFF, 2'h3, 22'h200000}};
  logic        clk_in = 1'b0;
  logic        rst_n_in;
  logic        core_rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [21:0] fl_addr;
  logic [15:0] fl_rdata;
  logic [21:0] fl_block;
  logic [63:0] fl_wdata;
  logic        fl_erase;
  logic        fl_prog;
  logic        stall;
  int          err_count = 0;
  int          n_tests = 0;
  int          long_cnt = 0;
  int          base;
  logic [21:0] eff;
  logic [31:0] rv;
  logic [1:0]  rr;
  tpf_top #(.LONG_OP_CYCLES(LONGC)) i_tpf_top (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .CORE_RST_IN(core_rst),
    .S_AWADDR_IN(awaddr), .S_AWVALID_IN(awvalid), .S_AWREADY_OUT(awready), .S_WDATA_IN(wdata),
    .S_WSTRB_IN(wstrb), .S_WVALID_IN(wvalid), .S_WREADY_OUT(wready), .S_BRESP_OUT(bresp),
    .S_BVALID_OUT(bvalid), .S_BREADY_IN(bready), .S_ARADDR_IN(araddr), .S_ARVALID_IN(arvalid),
    .S_ARREADY_OUT(arready), .S_RDATA_OUT(rdata), .S_RRESP_OUT(rresp), .S_RVALID_OUT(rvalid),
    .S_RREADY_IN(rready), .FL_ADDR_OUT(fl_addr), .FL_RDATA_IN(fl_rdata), .FL_BLOCK_OUT(fl_block),
    .FL_WDATA_OUT(fl_wdata), .FL_ERASE_OUT(fl_erase), .FL_PROG_OUT(fl_prog), .STALL_OUT(stall));
  tpf_flash_model i_tpf_flash_model (.addr_in(fl_addr), .rdata_out(fl_rdata));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // Sampled on the falling edge so the count never races the design's own update.
  always @(negedge clk_in) begin
    if (fl_prog | fl_erase) long_cnt <= long_cnt + 1;
  end
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Every wait is bounded so a hung handshake ends the run instead of the simulator.
  task automatic guard(inout int n);
    n++;
    if (n > 1000) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    int n;
    logic [1:0] r;
    n = 0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge clk_in);
    while (awready !== 1'b1 || wready !== 1'b1) begin @(negedge clk_in); guard(n); end
    @(posedge clk_in);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge clk_in);
    while (bvalid !== 1'b1) begin @(negedge clk_in); guard(n); end
    r = bresp;
    @(posedge clk_in);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge clk_in);
    while (arready !== 1'b1) begin @(negedge clk_in); guard(n); end
    @(posedge clk_in);
    arvalid <= 1'b0;
    @(negedge clk_in);
    while (rvalid !== 1'b1) begin @(negedge clk_in); guard(n); end
    d = rdata;
    r = rresp;
    @(posedge clk_in);
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OK});
    chk(d, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk_in);
    while (stall !== 1'b0) begin @(negedge clk_in); guard(n); end
  endtask
  task automatic unlock(input logic [31:0] c);
    wr(OFS_KEY, {24'h0, KEY_FIRST});
    wr(OFS_KEY, {24'h0, KEY_SECOND});
    wr(OFS_CTRL, c);
  endtask
  function automatic logic [7:0] flash_byte(input logic [21:0] a);
    flash_byte = a[0] ? ~{a[21], a[7:1]} : {a[21], a[7:1]};
  endfunction
  initial begin
    {rst_n_in, core_rst, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk(OFS_PTR, 32'h0);
    rd_chk(OFS_CTRL, 32'h0);
    foreach (ROWS[i]) begin
      eff = (ROWS[i].m == 2'h3) ? ROWS[i].np : ROWS[i].p;
      wr(OFS_PTR, {10'h0, ROWS[i].p});
      wr(OFS_TOP, {30'h0, ROWS[i].m});
      wait_idle();
      chk({10'h0, fl_addr}, {10'h0, eff});
      rd_chk(OFS_LATCH, {24'h0, flash_byte(eff)});
      rd_chk(OFS_PTR, {10'h0, ROWS[i].np});
    end
    wr(OFS_PTR, 32'h107);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_LATCH, 32'h10 + i);
      wr(OFS_TOP, 32'h7);
    end
    chk(fl_wdata[31:0], 32'h13121110);
    chk(fl_wdata[63:32], 32'h17161514);
    chk({31'h0, fl_erase | fl_prog}, 32'h0);
    base = long_cnt;
    unlock(32'h86);
    #1 chk({30'h0, fl_prog, stall}, 32'h3);
    chk({10'h0, fl_block}, 32'h108);
    rd_chk(OFS_CTRL, 32'h86);
    rd_chk(OFS_STAT, 32'h6);
    wr(OFS_CTRL, 32'h80);
    wr(OFS_LATCH, 32'hEE);
    wr(OFS_TOP, 32'h7);
    wait_idle();
    chk(long_cnt - base, LONGC);
    chk(fl_wdata[63:32], 32'h17161514);
    rd_chk(OFS_CTRL, 32'h84);
    rd_chk(OFS_STAT, 32'h1);
    wr(OFS_STAT, 32'h1);
    rd_chk(OFS_STAT, 32'h0);
    wr(OFS_PTR, 32'h1FF);
    base = long_cnt;
    unlock(32'h96);
    #1 chk({30'h0, fl_erase, stall}, 32'h3);
    chk({10'h0, fl_block}, 32'h1C0);
    wait_idle();
    chk(long_cnt - base, LONGC);
    rd_chk(OFS_CTRL, 32'h84);
    wr(OFS_KEY, {24'h0, KEY_FIRST});
    wr(OFS_PTR, 32'h0);
    wr(OFS_KEY, {24'h0, KEY_SECOND});
    wr(OFS_CTRL, 32'h86);
    #1 chk({30'h0, fl_erase | fl_prog, stall}, 32'h0);
    unlock(32'h92);
    #1 chk({30'h0, fl_erase | fl_prog, stall}, 32'h0);
    unlock(32'h16);
    #1 chk({30'h0, fl_erase | fl_prog, stall}, 32'h0);
    wr(OFS_CTRL, 32'h84);
    unlock(32'h86);
    repeat (3) @(posedge clk_in);
    core_rst <= 1'b1;
    @(posedge clk_in);
    core_rst <= 1'b0;
    @(negedge clk_in);
    chk({31'h0, fl_prog}, 32'h0);
    rd_chk(OFS_CTRL, 32'h88);
    wr(8'h18, 32'h0, RESP_ERR);
    rd(8'h18, rv, rr);
    chk({30'h0, rr}, {30'h0, RESP_ERR});
    stop_test();
  end
endmodule // tpf_top_tb
`default_nettype wire

// *** src/tpf_pkg.sv ***
// Constants, register map and field layouts of the table pointer flash block.
// Assumes a 20 MHz core clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package tpf_pkg;
  localparam int PTR_W = 22;
  localparam int LOW_W = 21;
  localparam int NHOLD = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LONG_OP_US = 2000;
  localparam int LONG_OP_CYC = LONG_OP_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] OFS_PTR = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0C;
  localparam logic [7:0] OFS_TOP = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int TOP_WRITE_BIT = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_LONG_BIT = 2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int ERASE_LSB = 6;
  localparam int PROG_LSB = 3;
  typedef enum logic [1:0] {
    PU_NONE = 2'h0, PU_POST_INC = 2'h1, PU_POST_DEC = 2'h2, PU_PRE_INC = 2'h3
  } tpf_upd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_RD_WAIT = 3'h2, ST_LONG = 3'h4
  } tpf_state_t;
  typedef enum logic [1:0] {
    KS_NONE = 2'h0, KS_FIRST = 2'h1, KS_ARMED = 2'h2
  } tpf_key_t;
  typedef struct packed {
    logic prog_space_select;
    logic config_space_select;
    logic rsvd;
    logic row_erase;
    logic program_abort_flag;
    logic write_enable_bit;
    logic start;
    logic rd;
  } tpf_ctrl_t;
  localparam tpf_ctrl_t CTRL_RST = '0;
endpackage : tpf_pkg
`default_nettype wire

// *** src/tpf_top.sv ***
// Table pointer, table latch, holding registers and long erase/program timer.
// Assumes a flash array that returns the 16-bit word in the same cycle as the address.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module tpf_top
  import tpf_pkg::*;
#(
  parameter int LONG_OP_CYCLES = LONG_OP_CYC
) (
  input  wire logic                CLK_IN,
  input  wire logic                RST_N_IN,
  input  wire logic                CORE_RST_IN,
  input  wire logic [7:0]          S_AWADDR_IN,
  input  wire logic                S_AWVALID_IN,
  output logic                     S_AWREADY_OUT,
  input  wire logic [31:0]         S_WDATA_IN,
  input  wire logic [3:0]          S_WSTRB_IN,
  input  wire logic                S_WVALID_IN,
  output logic                     S_WREADY_OUT,
  output logic [1:0]               S_BRESP_OUT,
  output logic                     S_BVALID_OUT,
  input  wire logic                S_BREADY_IN,
  input  wire logic [7:0]          S_ARADDR_IN,
  input  wire logic                S_ARVALID_IN,
  output logic                     S_ARREADY_OUT,
  output logic [31:0]              S_RDATA_OUT,
  output logic [1:0]               S_RRESP_OUT,
  output logic                     S_RVALID_OUT,
  input  wire logic                S_RREADY_IN,
  output logic [PTR_W-1:0]         FL_ADDR_OUT,
  input  wire logic [15:0]         FL_RDATA_IN,
  output logic [PTR_W-1:0]         FL_BLOCK_OUT,
  output logic [NHOLD*8-1:0]       FL_WDATA_OUT,
  output logic                     FL_ERASE_OUT,
  output logic                     FL_PROG_OUT,
  output logic                     STALL_OUT
);
  localparam int CW = $clog2(LONG_OP_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(LONG_OP_CYCLES - 1);

  tpf_state_t       state_reg, state_next;
  tpf_key_t         key_reg, key_next;
  tpf_ctrl_t        ctrl_reg, ctrl_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next, eff;
  logic [PTR_W-1:0] fladdr_reg, fladdr_next, blk_reg, blk_next;
  logic [7:0]       latch_reg, latch_next;
  logic [7:0]       hold_reg [NHOLD];
  logic [7:0]       hold_next [NHOLD];
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             erase_reg, erase_next, done_reg, done_next;
  logic             bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]       bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             wr_fire, rd_fire, wmapped, in_long;
  tpf_ctrl_t        wctrl;
  tpf_upd_t         mode;

  assign wr_fire = S_AWVALID_IN && S_WVALID_IN && !bvalid_reg;
  assign rd_fire = S_ARVALID_IN && !rvalid_reg;
  assign S_AWREADY_OUT = wr_fire;
  assign S_WREADY_OUT = wr_fire;
  assign S_ARREADY_OUT = rd_fire;
  assign wctrl = tpf_ctrl_t'(S_WDATA_IN[7:0]);
  assign mode = tpf_upd_t'(S_WDATA_IN[1:0]);
  assign in_long = (state_reg == ST_LONG);
  assign wmapped = (S_AWADDR_IN[7:2] <= OFS_STAT[7:2]) && (S_AWADDR_IN[1:0] == 2'h0);

  always_comb begin
    state_next = state_reg;
    key_next = key_reg;
    ctrl_next = ctrl_reg;
    ptr_next = ptr_reg;
    fladdr_next = fladdr_reg;
    blk_next = blk_reg;
    latch_next = latch_reg;
    hold_next = hold_reg;
    cnt_next = cnt_reg;
    erase_next = erase_reg;
    done_next = done_reg;
    bvalid_next = bvalid_reg && !S_BREADY_IN;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !S_RREADY_IN;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    eff = ptr_reg;
    if (mode == PU_PRE_INC) begin
      eff[LOW_W-1:0] = ptr_reg[LOW_W-1:0] + LOW_W'(1);
    end
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next = wmapped ? RESP_OK : RESP_ERR;
      // Any write other than the next key step breaks the unlock chain.
      key_next = KS_NONE;
      if (!in_long && S_AWADDR_IN == OFS_KEY && S_WDATA_IN[7:0] == KEY_FIRST) begin
        key_next = KS_FIRST;
      end
      if (!in_long && S_AWADDR_IN == OFS_KEY && S_WDATA_IN[7:0] == KEY_SECOND && key_reg == KS_FIRST) begin
        key_next = KS_ARMED;
      end
      if (!in_long && state_reg == ST_IDLE && wmapped) begin
        unique case (S_AWADDR_IN)
          OFS_PTR: begin
            for (int b = 0; b < 2; b++) begin
              if (S_WSTRB_IN[b]) begin
                ptr_next[b*8 +: 8] = S_WDATA_IN[b*8 +: 8];
              end
            end
            // The upper byte lane carries only the six bits that the pointer really has.
            if (S_WSTRB_IN[2]) begin
              ptr_next[PTR_W-1:16] = S_WDATA_IN[PTR_W-1:16];
            end
          end
          OFS_LATCH: if (S_WSTRB_IN[0]) latch_next = S_WDATA_IN[7:0];
          OFS_CTRL: if (S_WSTRB_IN[0]) begin
            ctrl_next = wctrl;
            ctrl_next.rsvd = 1'b0;
            ctrl_next.rd = 1'b0;
            ctrl_next.start = ctrl_reg.start;
            if (wctrl.start && key_reg == KS_ARMED && wctrl.prog_space_select
                && wctrl.write_enable_bit) begin
              ctrl_next.start = 1'b1;
              state_next = ST_LONG;
              cnt_next = '0;
              erase_next = wctrl.row_erase;
              // Erase ignores bits 5:0 and programming bits 2:0 of the pointer.
              blk_next = wctrl.row_erase ? {ptr_reg[PTR_W-1:ERASE_LSB], 6'h00}
                                         : {ptr_reg[PTR_W-1:PROG_LSB], 3'h0};
            end
          end
          OFS_TOP: begin
            unique case (mode)
              PU_POST_INC: ptr_next[LOW_W-1:0] = ptr_reg[LOW_W-1:0] + LOW_W'(1);
              PU_POST_DEC: ptr_next[LOW_W-1:0] = ptr_reg[LOW_W-1:0] - LOW_W'(1);
              PU_PRE_INC: ptr_next = eff;
              PU_NONE: ptr_next = ptr_reg;
            endcase
            if (S_WDATA_IN[TOP_WRITE_BIT]) begin
              hold_next[eff[2:0]] = latch_reg;
            end else begin
              fladdr_next = eff;
              state_next = ST_RD_WAIT;
            end
          end
          default: ;
        endcase
      end
      if (S_AWADDR_IN == OFS_STAT && S_WSTRB_IN[0] && S_WDATA_IN[STAT_DONE_BIT]) begin
        done_next = 1'b0;
      end
    end
    if (state_reg == ST_RD_WAIT) begin
      latch_next = fladdr_reg[0] ? FL_RDATA_IN[15:8] : FL_RDATA_IN[7:0];
      state_next = ST_IDLE;
    end
    if (in_long) begin
      cnt_next = cnt_reg + CW'(1);
      if (cnt_reg == CNT_LAST) begin
        state_next = ST_IDLE;
        ctrl_next.start = 1'b0;
        if (erase_reg) begin
          ctrl_next.row_erase = 1'b0;
        end
        done_next = 1'b1;
        erase_next = 1'b0;
      end
    end
    if (CORE_RST_IN) begin
      if (in_long) begin
        ctrl_next.program_abort_flag = 1'b1;
      end
      ctrl_next.start = 1'b0;
      ctrl_next.row_erase = 1'b0;
      ctrl_next.write_enable_bit = 1'b0;
      state_next = ST_IDLE;
      key_next = KS_NONE;
      erase_next = 1'b0;
      ptr_next = '0;
      latch_next = '0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OK;
      rdata_next = '0;
      unique case (S_ARADDR_IN)
        OFS_PTR: rdata_next[PTR_W-1:0] = ptr_reg;
        OFS_LATCH: rdata_next[7:0] = latch_reg;
        OFS_CTRL: rdata_next[7:0] = ctrl_reg;
        OFS_KEY: rdata_next = '0;
        OFS_TOP: rdata_next = '0;
        OFS_STAT: begin
          rdata_next[STAT_DONE_BIT] = done_reg;
          rdata_next[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
          rdata_next[STAT_LONG_BIT] = in_long;
        end
        default: rresp_next = RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_IDLE;
      key_reg <= KS_NONE;
      ctrl_reg <= CTRL_RST;
      ptr_reg <= '0;
      fladdr_reg <= '0;
      blk_reg <= '0;
      latch_reg <= '0;
      hold_reg <= '{default: '0};
      cnt_reg <= '0;
      erase_reg <= 1'b0;
      done_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OK;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OK;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      key_reg <= key_next;
      ctrl_reg <= ctrl_next;
      ptr_reg <= ptr_next;
      fladdr_reg <= fladdr_next;
      blk_reg <= blk_next;
      latch_reg <= latch_next;
      hold_reg <= hold_next;
      cnt_reg <= cnt_next;
      erase_reg <= erase_next;
      done_reg <= done_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  for (genvar i = 0; i < NHOLD; i++) begin : g_hold
    assign FL_WDATA_OUT[i*8 +: 8] = hold_reg[i];
  end

  assign S_BVALID_OUT = bvalid_reg;
  assign S_BRESP_OUT = bresp_reg;
  assign S_RVALID_OUT = rvalid_reg;
  assign S_RRESP_OUT = rresp_reg;
  assign S_RDATA_OUT = rdata_reg;
  assign FL_ADDR_OUT = fladdr_reg;
  assign FL_BLOCK_OUT = blk_reg;
  assign FL_ERASE_OUT = in_long && erase_reg;
  assign FL_PROG_OUT = in_long && !erase_reg;
  // The core is held during the read turn-around as well, so a latch read never returns stale data.
  assign STALL_OUT = (state_reg != ST_IDLE);

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic top_op;
  assign top_op = wr_fire && S_AWADDR_IN == OFS_TOP && state_reg == ST_IDLE && !CORE_RST_IN;
  sequence s_start;
    $rose(in_long);
  endsequence
  sequence s_end;
    $fell(in_long) && !$past(CORE_RST_IN);
  endsequence

  chk_start_unlocked: assert property (s_start |-> $past(key_reg) == KS_ARMED)
    else $error("Long cycle began without unlock.");
  chk_stall_held: assert property (in_long && cnt_reg != CNT_LAST && !CORE_RST_IN |=> STALL_OUT && in_long)
    else $error("Core not stalled in long cycle.");
  chk_timer_bound: assert property (in_long |-> cnt_reg <= CNT_LAST)
    else $error("Long cycle overran its timer.");
  chk_erase_gate: assert property (FL_ERASE_OUT |-> ctrl_reg.prog_space_select
      && ctrl_reg.write_enable_bit && ctrl_reg.row_erase && blk_reg[5:0] == 6'h00)
    else $error("Erase without its enables.");
  chk_end_clears: assert property (s_end |-> !ctrl_reg.start && done_reg
      && !($past(erase_reg) && ctrl_reg.row_erase))
    else $error("Completion bits wrong.");
  chk_hold_frozen: assert property (in_long && $past(in_long) |-> FL_WDATA_OUT == $past(FL_WDATA_OUT))
    else $error("Holding registers changed in long cycle.");
  chk_abort_flag: assert property (CORE_RST_IN && in_long |=> ctrl_reg.program_abort_flag
      && ctrl_reg.prog_space_select == $past(ctrl_reg.prog_space_select))
    else $error("Abort not flagged.");
  chk_ptr_top: assert property (top_op |=> ptr_reg[PTR_W-1] == $past(ptr_reg[PTR_W-1]))
    else $error("Pointer top bit moved.");
  chk_post_inc: assert property (top_op && mode == PU_POST_INC |=>
      ptr_reg[LOW_W-1:0] == $past(ptr_reg[LOW_W-1:0]) + LOW_W'(1))
    else $error("Post increment wrong.");
  chk_read_byte: assert property (state_reg == ST_RD_WAIT && !CORE_RST_IN |=> latch_reg ==
      ($past(fladdr_reg[0]) ? $past(FL_RDATA_IN[15:8]) : $past(FL_RDATA_IN[7:0])))
    else $error("Wrong byte in table latch.");
endmodule // tpf_top
`default_nettype wire
